/* File: design/liu_cfg_pkg.sv */
// shared constants and types for the line unit global configuration bank
// assumes a 32-bit ahb-lite register bus, one word per register index
`default_nettype none
package liu_cfg_pkg;

   // ----------------------------------------
   // register indices (byte address = 4 * index)
   // ----------------------------------------
   localparam logic [29:0] idx_first_global_control = 30'h0fe1;
   localparam logic [29:0] idx_master_clock_rate_config = 30'h0fe4;
   localparam logic [29:0] idx_interrupt_summary = 30'h0fea;
   localparam logic [29:0] idx_transmit_timing_channel_enables = 30'h0ff0;
   localparam logic [29:0] idx_receive_timing_channel_enables = 30'h0ff1;
   localparam logic [29:0] idx_event_status = 30'h0ff8;
   localparam logic [29:0] idx_event_mask = 30'h0ff9;

   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int global_transmit_timing_bit = 7;
   localparam int global_receive_timing_bit = 6;
   localparam int channel0_flag_bit = 0;
   localparam int ev_channel0_bit = 0;
   localparam int ev_reserved_rate_bit = 1;
   localparam int num_channels = 8;
   localparam int num_events = 2;

   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [7:0] rst_master_clock_rate_config = 8'h01;
   localparam logic [7:0] rst_first_global_control = 8'h00;
   localparam logic [7:0] rst_channel_enables = 8'h00;
   localparam logic [1:0] rst_events = 2'h0;

   // ----------------------------------------
   // rate select codes
   // ----------------------------------------
   localparam logic [3:0] code_2048_a = 4'h0;
   localparam logic [3:0] code_1544_a = 4'h1;
   localparam logic [3:0] code_4096 = 4'h8;
   localparam logic [3:0] code_3088 = 4'h9;
   localparam logic [3:0] code_8192 = 4'ha;
   localparam logic [3:0] code_6176 = 4'hb;
   localparam logic [3:0] code_16384 = 4'hc;
   localparam logic [3:0] code_12352 = 4'hd;
   localparam logic [3:0] code_2048_b = 4'he;
   localparam logic [3:0] code_1544_b = 4'hf;

   typedef enum logic [3:0] {
      rate_2048, rate_1544, rate_4096, rate_3088, rate_8192,
      rate_6176, rate_16384, rate_12352, rate_reserved
   } rate_t;

   typedef enum logic [1:0] {bus_idle, bus_write, bus_read} bus_state_t;

   typedef struct packed {
      logic [7:0] tx_active;
      logic [7:0] rx_active;
      logic global_tx;
      logic global_rx;
   } timing_ctl_t;

endpackage : liu_cfg_pkg
`default_nettype wire

/* File: design/rate_decode.sv */
// decodes the four-bit master clock rate select code
// assumes a stable code from a register; purely combinational
`timescale 1ns/1ps
`default_nettype none
module rate_decode (
   // code in
   input wire logic [3:0] code,
   // decoded rate
   output liu_cfg_pkg::rate_t rate
);
   always_comb begin
      case (code)
         liu_cfg_pkg::code_2048_a, liu_cfg_pkg::code_2048_b: rate = liu_cfg_pkg::rate_2048;
         liu_cfg_pkg::code_1544_a, liu_cfg_pkg::code_1544_b: rate = liu_cfg_pkg::rate_1544;
         liu_cfg_pkg::code_4096: rate = liu_cfg_pkg::rate_4096;
         liu_cfg_pkg::code_3088: rate = liu_cfg_pkg::rate_3088;
         liu_cfg_pkg::code_8192: rate = liu_cfg_pkg::rate_8192;
         liu_cfg_pkg::code_6176: rate = liu_cfg_pkg::rate_6176;
         liu_cfg_pkg::code_16384: rate = liu_cfg_pkg::rate_16384;
         liu_cfg_pkg::code_12352: rate = liu_cfg_pkg::rate_12352;
         default: rate = liu_cfg_pkg::rate_reserved;
      endcase
   end
endmodule : rate_decode
`default_nettype wire

/* File: design/line_unit_global_config_regs.sv */
// global configuration and status registers of the line unit
// assumes a single ahb-lite master; channel event is synchronous to hclk
//
// Added by the designer: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module line_unit_global_config_regs (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // channel 0 interrupt event, one pulse per occurrence
   input wire logic channel0_event,
   // configuration outputs
   output logic [3:0] master_clock_rate_select,
   output liu_cfg_pkg::rate_t master_clock_rate,
   output liu_cfg_pkg::timing_ctl_t timing,
   // interrupt
   output logic irq
);

   // ----------------------------------------
   // state
   // ----------------------------------------
   liu_cfg_pkg::bus_state_t bus_state;
   logic [29:0] idx;
   logic [7:0] rate_cfg;
   logic [7:0] gcr1;
   logic [7:0] tx_en;
   logic [7:0] rx_en;
   logic channel0_interrupt_flag;
   logic [1:0] ev_status;
   logic [1:0] ev_mask;
   logic accept;
   logic do_write;
   logic do_read;
   logic [31:0] rd_mux;
   logic [1:0] ev_set;
   liu_cfg_pkg::rate_t next_rate;
   logic [7:0] next_tx_active;
   logic [7:0] next_rx_active;

   // hsize is ignored: only whole-word transfers are expected
   assign accept = hsel && hready && htrans[1];
   assign do_write = (bus_state == liu_cfg_pkg::bus_write);
   assign do_read = (bus_state == liu_cfg_pkg::bus_read);

   // ----------------------------------------
   // bus sequencing
   // ----------------------------------------
   // reads take one wait state so a write just before is already visible
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bus_state <= liu_cfg_pkg::bus_idle;
         idx <= 30'h0;
         hreadyout <= 1'b1;
      end else if (accept) begin
         bus_state <= hwrite ? liu_cfg_pkg::bus_write : liu_cfg_pkg::bus_read;
         idx <= haddr[31:2];
         hreadyout <= hwrite;
      end else begin
         bus_state <= liu_cfg_pkg::bus_idle;
         hreadyout <= 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hresp <= 1'b0;
      end else begin
         hresp <= 1'b0;
      end
   end

   // ----------------------------------------
   // read mux
   // ----------------------------------------
   always_comb begin
      rd_mux = 32'h0;
      case (idx)
         liu_cfg_pkg::idx_first_global_control: rd_mux[7:0] = gcr1;
         liu_cfg_pkg::idx_master_clock_rate_config: rd_mux[7:0] = rate_cfg;
         liu_cfg_pkg::idx_interrupt_summary: rd_mux[liu_cfg_pkg::channel0_flag_bit] = channel0_interrupt_flag;
         liu_cfg_pkg::idx_transmit_timing_channel_enables: rd_mux[7:0] = tx_en;
         liu_cfg_pkg::idx_receive_timing_channel_enables: rd_mux[7:0] = rx_en;
         liu_cfg_pkg::idx_event_status: rd_mux[1:0] = ev_status;
         liu_cfg_pkg::idx_event_mask: rd_mux[1:0] = ev_mask;
         default: rd_mux = 32'h0;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0;
      end else if (do_read) begin
         hrdata <= rd_mux;
      end
   end

   // ----------------------------------------
   // configuration registers
   // ----------------------------------------
   // rate select, all eight written bits stored
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rate_cfg <= liu_cfg_pkg::rst_master_clock_rate_config;
      end else if (do_write && idx == liu_cfg_pkg::idx_master_clock_rate_config) begin
         rate_cfg <= hwdata[7:0];
      end
   end

   // global enables held here with plain storage bits
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         gcr1 <= liu_cfg_pkg::rst_first_global_control;
      end else if (do_write && idx == liu_cfg_pkg::idx_first_global_control) begin
         gcr1 <= hwdata[7:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_en <= liu_cfg_pkg::rst_channel_enables;
      end else if (do_write && idx == liu_cfg_pkg::idx_transmit_timing_channel_enables) begin
         tx_en <= hwdata[7:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_en <= liu_cfg_pkg::rst_channel_enables;
      end else if (do_write && idx == liu_cfg_pkg::idx_receive_timing_channel_enables) begin
         rx_en <= hwdata[7:0];
      end
   end

   // ----------------------------------------
   // channel 0 summary flag
   // ----------------------------------------
   // read clears, a same-cycle event keeps it set
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         channel0_interrupt_flag <= 1'b0;
      end else if (channel0_event) begin
         channel0_interrupt_flag <= 1'b1;
      end else if (do_read && idx == liu_cfg_pkg::idx_interrupt_summary) begin
         channel0_interrupt_flag <= 1'b0;
      end
   end

   // ----------------------------------------
   // event status, mask and interrupt
   // ----------------------------------------
   // reserved-code writes are flagged so software can catch the mistake
   always_comb begin
      ev_set = 2'h0;
      ev_set[liu_cfg_pkg::ev_channel0_bit] = channel0_event;
      ev_set[liu_cfg_pkg::ev_reserved_rate_bit] = do_write &&
         idx == liu_cfg_pkg::idx_master_clock_rate_config && hwdata[3:1] != 3'h0 && hwdata[3] == 1'b0;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ev_status <= liu_cfg_pkg::rst_events;
      end else if (do_write && idx == liu_cfg_pkg::idx_event_status) begin
         ev_status <= (ev_status & ~hwdata[1:0]) | ev_set;
      end else begin
         ev_status <= ev_status | ev_set;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ev_mask <= liu_cfg_pkg::rst_events;
      end else if (do_write && idx == liu_cfg_pkg::idx_event_mask) begin
         ev_mask <= hwdata[1:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(ev_status & ev_mask);
      end
   end

   // ----------------------------------------
   // rate decode and timing outputs
   // ----------------------------------------
   rate_decode u_rate_decode (
      .code(rate_cfg[3:0]),
      .rate(next_rate)
   );

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         master_clock_rate_select <= liu_cfg_pkg::rst_master_clock_rate_config[3:0];
         master_clock_rate <= liu_cfg_pkg::rate_1544;
      end else begin
         master_clock_rate_select <= rate_cfg[3:0];
         master_clock_rate <= next_rate;
      end
   end

   // each channel gated only by its own bit and the global bit
   for (genvar ch = 0; ch < liu_cfg_pkg::num_channels; ch++) begin : g_chan
      assign next_tx_active[ch] = tx_en[ch] && gcr1[liu_cfg_pkg::global_transmit_timing_bit];
      assign next_rx_active[ch] = rx_en[ch] && gcr1[liu_cfg_pkg::global_receive_timing_bit];
   end

   // globals go out to the line driver and recovery logic
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         timing <= '0;
      end else begin
         timing.tx_active <= next_tx_active;
         timing.rx_active <= next_rx_active;
         timing.global_tx <= gcr1[liu_cfg_pkg::global_transmit_timing_bit];
         timing.global_rx <= gcr1[liu_cfg_pkg::global_receive_timing_bit];
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   sequence s_read_summary;
      do_read && idx == liu_cfg_pkg::idx_interrupt_summary;
   endsequence

   sequence s_write_rate;
      do_write && idx == liu_cfg_pkg::idx_master_clock_rate_config;
   endsequence

   chk_rate_low_codes: assert property (
      (rate_cfg[3:0] == liu_cfg_pkg::code_2048_a || rate_cfg[3:0] == liu_cfg_pkg::code_2048_b)
      |=> master_clock_rate == liu_cfg_pkg::rate_2048)
      else $error("low rate code decoded wrong");

   chk_rate_high_codes: assert property (
      (rate_cfg[3:0] == liu_cfg_pkg::code_16384) |=> master_clock_rate == liu_cfg_pkg::rate_16384)
      else $error("code c not decoded as 16.384");

   chk_rate_write_lands: assert property (
      s_write_rate |=> ##1 master_clock_rate_select == $past(hwdata[3:0], 2))
      else $error("rate select write not seen on output");

   chk_summary_read_value: assert property (
      s_read_summary and channel0_interrupt_flag |=> hrdata[0] && hreadyout)
      else $error("set summary flag read as zero");

   chk_summary_read_clears: assert property (
      s_read_summary and !channel0_event |=> !channel0_interrupt_flag)
      else $error("summary read did not clear flag");

   chk_summary_event_wins: assert property (
      channel0_event |=> channel0_interrupt_flag)
      else $error("channel event lost");

   chk_summary_reserved_zero: assert property (
      s_read_summary |=> hrdata[31:1] == 31'h0)
      else $error("summary reserved bits not zero");

   chk_tx_gating: assert property (
      ##1 timing.tx_active == $past(tx_en & {8{gcr1[liu_cfg_pkg::global_transmit_timing_bit]}}))
      else $error("tx active not global and channel");

   chk_rx_gating: assert property (
      ##1 timing.rx_active == $past(rx_en & {8{gcr1[liu_cfg_pkg::global_receive_timing_bit]}}))
      else $error("rx active not global and channel");

   chk_irq_level: assert property (
      ##1 irq == $past(|(ev_status & ev_mask)))
      else $error("irq does not follow masked status");

endmodule : line_unit_global_config_regs
`default_nettype wire

/* File: dv/line_unit_global_config_regs_test.sv */
// self-checking bench for the line unit global configuration register bank
// assumes the design answers as a single ahb-lite slave with hready tied to hreadyout
`timescale 1ns/1ps
`default_nettype none
module line_unit_global_config_regs_test;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic channel0_event = 1'b0;
   wire logic hreadyout;
   wire logic hresp;
   wire logic [31:0] hrdata;
   wire logic [3:0] master_clock_rate_select;
   liu_cfg_pkg::rate_t master_clock_rate;
   liu_cfg_pkg::timing_ctl_t timing;
   wire logic irq;
   int fails = 0;
   int checks = 0;
   logic [31:0] seed = 32'h815a;

   always #20 hclk = ~hclk;

   line_unit_global_config_regs i_dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .channel0_event(channel0_event),
      .master_clock_rate_select(master_clock_rate_select), .master_clock_rate(master_clock_rate),
      .timing(timing), .irq(irq)
   );

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   function automatic liu_cfg_pkg::rate_t exp_rate(input logic [3:0] c);
      case (c)
         4'h0, 4'he: exp_rate = liu_cfg_pkg::rate_2048;
         4'h1, 4'hf: exp_rate = liu_cfg_pkg::rate_1544;
         4'h8: exp_rate = liu_cfg_pkg::rate_4096;
         4'h9: exp_rate = liu_cfg_pkg::rate_3088;
         4'ha: exp_rate = liu_cfg_pkg::rate_8192;
         4'hb: exp_rate = liu_cfg_pkg::rate_6176;
         4'hc: exp_rate = liu_cfg_pkg::rate_16384;
         4'hd: exp_rate = liu_cfg_pkg::rate_12352;
         default: exp_rate = liu_cfg_pkg::rate_reserved;
      endcase
   endfunction : exp_rate

   task automatic close_out;
      if (fails == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : close_out

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // bounded wait for a rising edge with hready high
   task automatic wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      if (n >= 20) begin
         fails++;
         $display("Error at %0t: bus never ready", $time);
      end
   endtask : wait_rdy

   task automatic xfer(input logic is_wr, input logic [29:0] idx, input logic [31:0] d, output logic [31:0] q);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= is_wr;
      haddr <= {idx, 2'b00};
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= is_wr ? d : 32'h0;
      wait_rdy();
      q = hrdata;
      chk({31'h0, hresp}, 32'h0);
   endtask : xfer

   task automatic wr(input logic [29:0] idx, input logic [31:0] d);
      logic [31:0] q;
      xfer(1'b1, idx, d, q);
   endtask : wr

   task automatic rd_chk(input logic [29:0] idx, input logic [31:0] e);
      logic [31:0] q;
      xfer(1'b0, idx, 32'h0, q);
      chk(q, e);
   endtask : rd_chk

   task automatic pulse_event;
      @(posedge hclk);
      channel0_event <= 1'b1;
      @(posedge hclk);
      channel0_event <= 1'b0;
   endtask : pulse_event

   initial begin
      #(40 * 20000);
      fails++;
      close_out();
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      logic [7:0] d;
      logic [7:0] tx;
      logic [7:0] rx;
      logic [7:0] g;
      repeat (3) @(posedge hclk);
      #1;
      chk({28'h0, master_clock_rate_select}, 32'h1);
      chk(32'(timing), 32'h0);
      @(posedge hclk);
      hresetn <= 1'b1;
      rd_chk(liu_cfg_pkg::idx_master_clock_rate_config, 32'h01);
      rd_chk(liu_cfg_pkg::idx_interrupt_summary, 32'h0);
      rd_chk(liu_cfg_pkg::idx_transmit_timing_channel_enables, 32'h0);
      rd_chk(liu_cfg_pkg::idx_receive_timing_channel_enables, 32'h0);
      rd_chk(30'h0100, 32'h0);
      // every rate code, random upper bits
      for (int c = 0; c < 16; c++) begin
         seed = lfsr(seed);
         d = {seed[7:4], 4'(c)};
         wr(liu_cfg_pkg::idx_master_clock_rate_config, {24'h0, d});
         repeat (2) @(posedge hclk);
         #1;
         chk({28'h0, master_clock_rate_select}, 32'(c));
         chk(32'(master_clock_rate), 32'(exp_rate(4'(c))));
         rd_chk(liu_cfg_pkg::idx_master_clock_rate_config, {24'h0, d});
      end
      // reserved codes were written above and are flagged
      rd_chk(liu_cfg_pkg::idx_event_status, 32'h2);
      wr(liu_cfg_pkg::idx_event_status, 32'h3);
      rd_chk(liu_cfg_pkg::idx_event_status, 32'h0);
      // channel enables gated by globals, corners first
      for (int i = 0; i < 10; i++) begin
         seed = lfsr(seed);
         tx = (i == 0) ? 8'hff : (i == 1) ? 8'hfe : seed[7:0];
         rx = (i < 2) ? 8'h5a : seed[15:8];
         g = (i < 2) ? 8'hc0 : seed[23:16];
         wr(liu_cfg_pkg::idx_first_global_control, {24'h0, g});
         wr(liu_cfg_pkg::idx_transmit_timing_channel_enables, {24'h0, tx});
         wr(liu_cfg_pkg::idx_receive_timing_channel_enables, {24'h0, rx});
         repeat (2) @(posedge hclk);
         #1;
         chk({31'h0, timing.global_tx}, {31'h0, g[7]});
         chk({31'h0, timing.global_rx}, {31'h0, g[6]});
         chk({24'h0, timing.tx_active}, {24'h0, tx & {8{g[7]}}});
         chk({24'h0, timing.rx_active}, {24'h0, rx & {8{g[6]}}});
         rd_chk(liu_cfg_pkg::idx_transmit_timing_channel_enables, {24'h0, tx});
         rd_chk(liu_cfg_pkg::idx_receive_timing_channel_enables, {24'h0, rx});
         rd_chk(liu_cfg_pkg::idx_first_global_control, {24'h0, g});
      end
      // summary flag sets, then clears on read
      pulse_event();
      rd_chk(liu_cfg_pkg::idx_interrupt_summary, 32'h1);
      rd_chk(liu_cfg_pkg::idx_interrupt_summary, 32'h0);
      // masked event leaves irq low, unmasked raises it
      wr(liu_cfg_pkg::idx_event_mask, 32'h0);
      pulse_event();
      repeat (3) @(posedge hclk);
      #1;
      chk({31'h0, irq}, 32'h0);
      wr(liu_cfg_pkg::idx_event_mask, 32'h1);
      repeat (2) @(posedge hclk);
      #1;
      chk({31'h0, irq}, 32'h1);
      rd_chk(liu_cfg_pkg::idx_event_status, 32'h1);
      wr(liu_cfg_pkg::idx_event_status, 32'h1);
      repeat (2) @(posedge hclk);
      #1;
      chk({31'h0, irq}, 32'h0);
      rd_chk(liu_cfg_pkg::idx_interrupt_summary, 32'h1);
      // second reset mid-run brings defaults back
      @(posedge hclk);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      #1;
      chk({28'h0, master_clock_rate_select}, 32'h1);
      chk({31'h0, irq}, 32'h0);
      @(posedge hclk);
      hresetn <= 1'b1;
      rd_chk(liu_cfg_pkg::idx_transmit_timing_channel_enables, 32'h0);
      rd_chk(liu_cfg_pkg::idx_interrupt_summary, 32'h0);
      close_out();
   end
endmodule : line_unit_global_config_regs_test
`default_nettype wire
